// >>> pkg/pdp_pkg.sv
// Constants and types for the parallel display port
package pdp_pkg;

  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int TMR_W      = 12;

  // Times in ns and the clock period
  localparam int CLK_NS    = 4;
  localparam int T_WL_NS   = 50;
  localparam int T_WH_NS   = 50;
  localparam int T_DS_NS   = 25;
  localparam int T_RL_NS   = 150;
  localparam int T_RH_NS   = 150;
  localparam int T_INIT_NS = 10000;

  // Least time rounded up to whole cycles, never below one
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cycles

  localparam int WR_LOW_CYC  = ceil_cycles((T_WL_NS > T_DS_NS) ? T_WL_NS : T_DS_NS);
  localparam int WR_HIGH_CYC = ceil_cycles(T_WH_NS);
  localparam int RD_LOW_CYC  = ceil_cycles(T_RL_NS);
  localparam int RD_HIGH_CYC = ceil_cycles(T_RH_NS);
  localparam int INIT_CYC    = ceil_cycles(T_INIT_NS);

  localparam logic [TMR_W-1:0] WR_LOW_LD  = TMR_W'(WR_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] WR_HIGH_LD = TMR_W'(WR_HIGH_CYC - 1);
  localparam logic [TMR_W-1:0] RD_LOW_LD  = TMR_W'(RD_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] RD_HIGH_LD = TMR_W'(RD_HIGH_CYC - 1);
  localparam logic [TMR_W-1:0] INIT_LD    = TMR_W'(INIT_CYC - 1);

  // Select line levels
  localparam logic SEL_INDEX = 1'h0;
  localparam logic SEL_DATA  = 1'h1;

  typedef struct packed {
    logic              is_read;
    logic              sel;
    logic [DATA_W-1:0] data;
  } pdp_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_WR_LOW  = 3'h1,
    ST_WR_HIGH = 3'h2,
    ST_RD_LOW  = 3'h3,
    ST_RD_HIGH = 3'h4,
    ST_INIT    = 3'h5
  } pdp_state_t;

endpackage : pdp_pkg

// >>> hw/pdp_port.sv
// Parallel display port engine with its command FIFO
`timescale 1ns/1ns

module pdp_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic [AW:0]   count_d;
  logic          push;
  logic          pop;
  logic          rdy_q;

  assign push      = in_valid && rdy_q;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_ptr_q];
  assign in_ready  = rdy_q;

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      rdy_q    <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_d;
      rdy_q   <= (count_d != (AW+1)'(DEPTH));
    end
  end

endmodule : pdp_fifo

module pdp_port
  import pdp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Command stream
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire pdp_cmd_t          cmd,
  // Read results
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  // Panel control requests
  input  wire logic              init_req,
  input  wire logic              boost_on,
  // Panel pins
  output logic                   panel_cs_n,
  output logic                   index_or_data_select,
  output logic                   panel_wr_n,
  output logic                   panel_rd_n,
  output logic [DATA_W-1:0]      panel_data_out,
  output logic                   panel_data_oe,
  input  wire logic [DATA_W-1:0] panel_data_in,
  output logic                   panel_init_pulse_n,
  output logic                   boost_supply_enable
);

  pdp_state_t        state_q;
  pdp_state_t        state_d;
  logic [TMR_W-1:0]  tmr_q;
  logic [TMR_W-1:0]  tmr_d;
  pdp_cmd_t          fifo_data;
  logic              fifo_valid;
  logic              fifo_ready;
  logic              init_pend_q;
  logic [DATA_W-1:0] din_meta_q;
  logic [DATA_W-1:0] din_sync_q;
  logic              tmr_done;

  pdp_fifo #(
    .W     ($bits(pdp_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  assign tmr_done   = (tmr_q == '0);
  assign fifo_ready = (state_q == ST_IDLE) && !init_pend_q;

  always_comb
  begin
    state_d = state_q;
    tmr_d   = tmr_done ? tmr_q : tmr_q - 1'b1;
    case (state_q)
      ST_IDLE:
      begin
        if (init_pend_q)
        begin
          state_d = ST_INIT;
          tmr_d   = INIT_LD;
        end
        else if (fifo_valid)
        begin
          state_d = fifo_data.is_read ? ST_RD_LOW : ST_WR_LOW;
          tmr_d   = fifo_data.is_read ? RD_LOW_LD : WR_LOW_LD;
        end
      end
      ST_WR_LOW,
      ST_RD_LOW:
      begin
        if (tmr_done)
        begin
          state_d = (state_q == ST_WR_LOW) ? ST_WR_HIGH : ST_RD_HIGH;
          tmr_d   = (state_q == ST_WR_LOW) ? WR_HIGH_LD : RD_HIGH_LD;
        end
      end
      ST_WR_HIGH,
      ST_RD_HIGH,
      ST_INIT:
      begin
        if (tmr_done)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      tmr_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
    end
  end

  // Init request latch, a new request beats the clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      init_pend_q <= 1'b0;
    else if (init_req)
      init_pend_q <= 1'b1;
    else if (state_q == ST_IDLE)
      init_pend_q <= 1'b0;
  end

  // Pin outputs registered: strobes from the next state, select and data from the FIFO head, boost from boost_on
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      panel_cs_n           <= 1'b1;
      index_or_data_select <= SEL_DATA;
      panel_wr_n           <= 1'b1;
      panel_rd_n           <= 1'b1;
      panel_data_out       <= '0;
      panel_data_oe        <= 1'b0;
      panel_init_pulse_n   <= 1'b1;
      boost_supply_enable  <= 1'b0;
    end
    else
    begin
      panel_cs_n         <= !(state_d inside {ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW,
                                              ST_RD_HIGH});
      panel_wr_n         <= (state_d != ST_WR_LOW);
      panel_rd_n         <= (state_d != ST_RD_LOW);
      panel_data_oe      <= (state_d inside {ST_WR_LOW, ST_WR_HIGH});
      panel_init_pulse_n <= (state_d != ST_INIT);
      boost_supply_enable <= boost_on;
      if (fifo_valid && fifo_ready)
      begin
        index_or_data_select <= fifo_data.sel;
        panel_data_out       <= fifo_data.data;
      end
    end
  end

  // Read data synchroniser and capture at the end of the strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      din_meta_q <= '0;
      din_sync_q <= '0;
      rsp_valid  <= 1'b0;
      rsp_data   <= '0;
    end
    else
    begin
      din_meta_q <= panel_data_in;
      din_sync_q <= din_meta_q;
      rsp_valid  <= (state_q == ST_RD_LOW) && tmr_done;
      if ((state_q == ST_RD_LOW) && tmr_done)
        rsp_data <= din_sync_q;
    end
  end

  // Helper counters for pulse widths
  logic [TMR_W-1:0] wr_low_cnt_q;
  logic [TMR_W-1:0] rd_low_cnt_q;
  logic [TMR_W-1:0] init_cnt_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_low_cnt_q <= '0;
      rd_low_cnt_q <= '0;
      init_cnt_q   <= '0;
    end
    else
    begin
      wr_low_cnt_q <= panel_wr_n ? '0 : wr_low_cnt_q + 1'b1;
      rd_low_cnt_q <= panel_rd_n ? '0 : rd_low_cnt_q + 1'b1;
      init_cnt_q   <= panel_init_pulse_n ? '0 : init_cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_strobe_excl: assert property (!(!panel_wr_n && !panel_rd_n))
    else $error("Read and write strobes low together");
  chk_oe_write_only: assert property (panel_data_oe |-> panel_rd_n)
    else $error("Data bus driven during a read");
  chk_cs_covers: assert property ((!panel_wr_n || !panel_rd_n) |-> !panel_cs_n)
    else $error("Strobe low without chip select");
  chk_wr_width: assert property ($rose(panel_wr_n) |-> wr_low_cnt_q == TMR_W'(WR_LOW_CYC))
    else $error("Write strobe low time wrong");
  chk_rd_width: assert property ($rose(panel_rd_n) |-> rd_low_cnt_q == TMR_W'(RD_LOW_CYC))
    else $error("Read strobe low time wrong");
  chk_sel_stable: assert property (!panel_cs_n && $past(!panel_cs_n)
                                   |-> $stable(index_or_data_select))
    else $error("Select line moved inside an access");
  chk_init_width: assert property ($rose(panel_init_pulse_n)
                                   |-> init_cnt_q == TMR_W'(INIT_CYC))
    else $error("Init pulse width wrong");
  chk_boost_follow: assert property (##1 boost_supply_enable == $past(boost_on))
    else $error("Converter enable did not follow request");
  chk_wr_drives: assert property ($fell(panel_wr_n) |-> panel_data_oe && !panel_cs_n
                                  ##WR_LOW_CYC panel_wr_n && panel_data_oe)
    else $error("Write phase sequence wrong");
  chk_rd_answer: assert property ($fell(panel_rd_n) |-> !rsp_valid [*2]
                                  ##[1:60] rsp_valid)
    else $error("Read produced no result");
  cov_write: cover property ($rose(panel_wr_n) && index_or_data_select);
  cov_index: cover property ($rose(panel_wr_n) && !index_or_data_select);
  cov_read: cover property (rsp_valid);
  cov_init: cover property ($rose(panel_init_pulse_n));
  cov_full: cover property (!cmd_ready);
endmodule : pdp_port

// >>> tb/pdp_panel_model.sv
// Behavioural panel controller on the far side of the display port
`timescale 1ns/1ns

module pdp_panel_model
  import pdp_pkg::*;
#(
  parameter logic [DATA_W-1:0] STATUS_WORD = 16'h5a3c
) (
  // Clock
  input  wire logic              clk,
  // Panel pins
  input  wire logic              panel_cs_n,
  input  wire logic              index_or_data_select,
  input  wire logic              panel_wr_n,
  input  wire logic              panel_rd_n,
  input  wire logic [DATA_W-1:0] panel_data_out,
  output logic [DATA_W-1:0]      panel_data_in,
  // Captured words
  output logic [DATA_W-1:0]      last_index,
  output logic [DATA_W-1:0]      last_data,
  output int                     n_writes
);
  logic              wr_n_q = 1'b1;
  logic [DATA_W-1:0] bus_q  = 16'h0000;

  initial
  begin
    last_index = 16'h0000;
    last_data  = 16'h0000;
    n_writes   = 0;
  end

  // Latch a written word at the end of the strobe, only while selected
  always @(posedge clk)
  begin
    wr_n_q <= panel_wr_n;
    bus_q  <= panel_data_in;
    if (wr_n_q === 1'b0 && panel_wr_n === 1'b1 && panel_cs_n === 1'b0)
    begin
      if (index_or_data_select === 1'b0)
        last_index <= panel_data_out;
      else
        last_data <= panel_data_out;
      n_writes <= n_writes + 1;
    end
  end

  // Drive the bus only during a selected read, else a changing pattern
  always_comb
  begin
    if (panel_cs_n === 1'b0 && panel_rd_n === 1'b0)
      panel_data_in = index_or_data_select ? last_data : STATUS_WORD;
    else
      panel_data_in = ~bus_q;
  end
endmodule : pdp_panel_model

// >>> tb/tb_top.sv
// Self-checking testbench for the parallel display port
`timescale 1ns/1ns

module tb_top;
  import pdp_pkg::*;

  logic              clk, reset_n, cmd_valid, cmd_ready, rsp_valid, init_req, boost_on;
  logic              cs_n, sel, wr_n, rd_n, oe, init_n, boost_en;
  logic [DATA_W-1:0] rsp_data, d_out, d_in, last_index, last_data;
  pdp_cmd_t          cmd;
  int                n_writes, mismatches, n_compared, refused;
  int                wr_run, rd_run, init_run;

  pdp_port pdp_port_inst (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_req(init_req), .boost_on(boost_on), .panel_cs_n(cs_n),
    .index_or_data_select(sel), .panel_wr_n(wr_n), .panel_rd_n(rd_n),
    .panel_data_out(d_out), .panel_data_oe(oe), .panel_data_in(d_in),
    .panel_init_pulse_n(init_n), .boost_supply_enable(boost_en));

  pdp_panel_model pdp_panel_model_inst (.clk(clk), .panel_cs_n(cs_n),
    .index_or_data_select(sel), .panel_wr_n(wr_n), .panel_rd_n(rd_n),
    .panel_data_out(d_out), .panel_data_in(d_in), .last_index(last_index),
    .last_data(last_data), .n_writes(n_writes));

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Offer a command and hold it until taken; valid stays up for back to back
  task automatic push(input logic rd, input logic s, input logic [DATA_W-1:0] d);
    cmd_valid <= 1'b1;
    cmd       <= pdp_cmd_t'{rd, s, d};
    for (int i = 0; i < 5000; i++)
    begin
      @(negedge clk);
      if (cmd_ready === 1'b1)
        break;
      refused++;
    end
    check(cmd_ready === 1'b1, "command never taken");
    @(posedge clk);
  endtask : push

  task automatic read_word(input logic s, input logic [DATA_W-1:0] exp);
    push(1'b1, s, 16'h0000);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 200 && rsp_valid !== 1'b1; i++)
      @(negedge clk);
    check(rsp_valid === 1'b1 && rsp_data === exp, "read word");
    @(posedge clk);
  endtask : read_word

  task automatic wait_writes(input int n);
    for (int i = 0; i < 5000 && n_writes != n; i++)
      @(negedge clk);
    check(n_writes == n, "writes missing");
    @(posedge clk);
  endtask : wait_writes

  task automatic test_writes();
    push(1'b0, SEL_INDEX, 16'h0022);
    push(1'b0, SEL_DATA, 16'ha5c3);
    cmd_valid <= 1'b0;
    wait_writes(2);
    check(last_index === 16'h0022 && last_data === 16'ha5c3, "write words");
  endtask : test_writes

  task automatic test_fill();
    refused = 0;
    for (int i = 0; i < 40; i++)
      push(1'b0, SEL_DATA, 16'h1000 + 16'(i));
    cmd_valid <= 1'b0;
    check(refused > 0, "fifo never refused");
    wait_writes(42);
    check(last_data === 16'h1027 && n_writes == 42, "drained order");
  endtask : test_fill

  task automatic test_init_boost();
    int low;
    low = 0;
    init_req <= 1'b1;
    boost_on <= 1'b1;
    @(posedge clk);
    init_req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(boost_en === 1'b1, "boost on");
    for (int i = 0; i < 100 && init_n !== 1'b0; i++)
      @(negedge clk);
    for (int i = 0; i < 3000 && init_n === 1'b0; i++)
    begin
      low++;
      @(negedge clk);
    end
    check(init_n === 1'b1 && low == INIT_CYC, "init pulse stuck");
    @(posedge clk);
    boost_on <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(boost_en === 1'b0, "boost off");
    @(posedge clk);
  endtask : test_init_boost

  // Strobe widths and bus ownership watched on every cycle
  always @(negedge clk)
  if (reset_n === 1'b1)
  begin
    check(!((wr_n === 1'b0 || rd_n === 1'b0) && cs_n !== 1'b0), "strobe w/o cs");
    check(!(wr_n === 1'b0 && rd_n === 1'b0), "both strobes");
    check(rd_n !== 1'b0 || oe === 1'b0, "driven during read");
    check(wr_n !== 1'b0 || oe === 1'b1, "released during write");
    if (wr_n === 1'b0) wr_run++;
    else if (wr_run != 0)
    begin
      check(wr_run == WR_LOW_CYC, "write strobe width");
      wr_run = 0;
    end
    if (rd_n === 1'b0) rd_run++;
    else if (rd_run != 0)
    begin
      check(rd_run == RD_LOW_CYC, "read strobe width");
      rd_run = 0;
    end
    if (init_n === 1'b0) init_run++;
    else if (init_run != 0)
    begin
      check(init_run == INIT_CYC, "init pulse width");
      init_run = 0;
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #80000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    reset_n = 1'b0; cmd_valid = 1'b0; cmd = '0; init_req = 1'b0; boost_on = 1'b0;
    mismatches = 0; n_compared = 0; refused = 0; wr_run = 0; rd_run = 0; init_run = 0;
    @(posedge clk);
    @(negedge clk);
    check(cs_n === 1'b1 && wr_n === 1'b1 && rd_n === 1'b1 && oe === 1'b0 &&
          init_n === 1'b1 && boost_en === 1'b0 && cmd_ready === 1'b0, "reset");
    @(posedge clk);
    reset_n <= 1'b1;
    test_writes();
    read_word(SEL_INDEX, 16'h5a3c);
    read_word(SEL_DATA, 16'ha5c3);
    test_fill();
    test_init_boost();
    give_verdict();
  end
endmodule : tb_top
